/* File: core/line_shape_pkg.sv */
package line_shape_pkg;

  localparam int NUM_CHAN = 4;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register indices; the byte address is four times the index.
  localparam logic [5:0] IDX_SHAPE_CHANNEL_SELECT = 6'h10;
  localparam logic [5:0] IDX_SHAPE_LINE_LENGTH_DATA = 6'h11;
  localparam logic [5:0] IDX_DRIVER_TRISTATE_CONTROL = 6'h12;
  localparam logic [5:0] IDX_ALARM_SIGNAL_STATUS = 6'h13;
  localparam logic [5:0] IDX_ALARM_IRQ_ENABLE = 6'h14;
  localparam logic [5:0] IDX_ALARM_IRQ_STATUS = 6'h15;
  localparam logic [5:0] IDX_ALARM_IRQ_CLEAR = 6'h16;

  // Field positions and widths.
  localparam int CHAN_PTR_LSB = 0;
  localparam int CHAN_PTR_W = 3;
  localparam int LEN_LSB = 0;
  localparam int LEN_W = 3;
  localparam int CHAN_BITS_LSB = 0;

  // Values after reset.
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [CHAN_PTR_W-1:0] CHAN_PTR_RESET = 3'h0;
  localparam logic [LEN_W-1:0] LEN_RESET = 3'h0;
  localparam logic [NUM_CHAN-1:0] CHAN_BITS_RESET = 4'h0;

  // Line length encodings.
  localparam logic [LEN_W-1:0] LEN_E1 = 3'h0;
  localparam logic [LEN_W-1:0] LEN_T1_FIRST = 3'h3;

  typedef enum {MODE_E1, MODE_T1, MODE_RESERVED} line_mode_e;

  typedef enum {
    REG_CHAN_SEL, REG_LEN_DATA, REG_TRISTATE, REG_ALARM_STAT,
    REG_IRQ_EN, REG_IRQ_STAT, REG_IRQ_CLEAR, REG_NONE
  } reg_sel_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic write;
    logic [DATA_W-1:0] wdata;
    logic [3:0] strb;
  } apb_req_s;

  typedef struct packed {
    logic [NUM_CHAN-1:0] monitor;
    logic [NUM_CHAN-1:0] irq_status;
  } alarm_view_s;

  function automatic line_mode_e decode_mode(input logic [LEN_W-1:0] code);
    if (code == LEN_E1) begin
      return MODE_E1;
    end else if (code >= LEN_T1_FIRST) begin
      return MODE_T1;
    end
    return MODE_RESERVED;
  endfunction

  function automatic reg_sel_e decode_reg(input logic [ADDR_W-1:0] addr);
    reg_sel_e sel;
    sel = REG_NONE;
    if (addr[1:0] == 2'h0) begin
      case (addr[7:2])
        IDX_SHAPE_CHANNEL_SELECT: sel = REG_CHAN_SEL;
        IDX_SHAPE_LINE_LENGTH_DATA: sel = REG_LEN_DATA;
        IDX_DRIVER_TRISTATE_CONTROL: sel = REG_TRISTATE;
        IDX_ALARM_SIGNAL_STATUS: sel = REG_ALARM_STAT;
        IDX_ALARM_IRQ_ENABLE: sel = REG_IRQ_EN;
        IDX_ALARM_IRQ_STATUS: sel = REG_IRQ_STAT;
        IDX_ALARM_IRQ_CLEAR: sel = REG_IRQ_CLEAR;
        default: sel = REG_NONE;
      endcase
    end
    return sel;
  endfunction

endpackage

/* File: core/alarm_irq_tracker.sv */
`timescale 1ns/100ps
module alarm_irq_tracker
  import line_shape_pkg::*;
(
  input wire logic pclk, // Register clock.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic pce, // Clock enable; state holds while low.
  input wire logic [NUM_CHAN-1:0] ais_detect, // Receiver alarm levels.
  input wire logic [NUM_CHAN-1:0] irq_enable, // Per-channel interrupt enable.
  input wire logic [NUM_CHAN-1:0] read_clear, // Bits cleared by a status read.
  input wire logic [NUM_CHAN-1:0] write_clear, // Bits cleared by a clear write.
  output alarm_view_s view, // Monitor and sticky status.
  output logic irq // Level interrupt.
);

  logic [NUM_CHAN-1:0] monitor_q;
  logic [NUM_CHAN-1:0] status_q;
  logic [NUM_CHAN-1:0] status_d;
  logic [NUM_CHAN-1:0] change;
  logic irq_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      monitor_q <= CHAN_BITS_RESET; // RL6
    end else if (pce) begin
      monitor_q <= ais_detect; // RL8
    end
  end

  // An edge arriving with a clear is kept, so no alarm change goes unseen.
  always_comb begin
    change = ais_detect ^ monitor_q; // RL11
    status_d = (status_q & ~(read_clear | write_clear)) | change; // RL9 RL11
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= CHAN_BITS_RESET; // RL6
    end else if (pce) begin
      status_q <= status_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else if (pce) begin
      irq_q <= |(status_d & irq_enable); // RL10 RL13
    end
  end

  assign view = '{monitor: monitor_q, irq_status: status_q};
  assign irq = irq_q;

endmodule

/* File: core/line_shape_ais_register_bank.sv */
// Implementation choice: register access over APB.
`timescale 1ns/100ps
// Overview of operation
// RL1 - Low three pointer bits pick channel zero-three
// RL2 - Data register accesses the pointed channel's setting
// RL3 - Codes 011 to 111 pick T1 shapes
// RL4 - Code zero selects E1 operation
// RL5 - Current revision reads line length inverted
// RL6 - All registers clear to zero at reset
// RL7 - Tristate bit set disables channel line driver
// RL8 - Status bit shows channel alarm detection
// RL9 - One status read clears pending alarm interrupts
// RL10 - Enable bit gates each channel's interrupt
// RL11 - Status bit set on alarm state change
// RL12 - Host writes zero to enable bits seven-four
// RL13 - Interrupt high while enabled status bit set
module line_shape_ais_register_bank
  import line_shape_pkg::*;
#(
  parameter bit READBACK_FIXED = 1'b0
)
(
  input wire logic pclk, // Bus clock, 200 MHz.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic pce, // Clock enable; all state holds while low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB access phase.
  input wire logic pwrite, // APB direction, high for write.
  input wire logic [ADDR_W-1:0] paddr, // APB byte address.
  input wire logic [DATA_W-1:0] pwdata, // APB write data.
  input wire logic [3:0] pstrb, // APB byte strobes.
  output logic [DATA_W-1:0] prdata, // APB read data, registered.
  output logic pready, // APB ready.
  output logic pslverr, // APB error for unmapped address.
  input wire logic [NUM_CHAN-1:0] ais_detect, // Alarm detected per receiver.
  output logic [NUM_CHAN-1:0][LEN_W-1:0] line_length_code, // Per channel code.
  output logic [NUM_CHAN-1:0] e1_mode, // Channel runs E1.
  output logic [NUM_CHAN-1:0] t1_mode, // Channel runs T1 with a valid shape.
  output logic [NUM_CHAN-1:0] driver_tristate_bits, // High puts driver in high Z.
  output logic irq // Alarm interrupt, active high level.
);

  apb_req_s req;
  reg_sel_e setup_sel;
  reg_sel_e access_sel;
  logic access_done;
  logic wr_lane0;
  logic wr_chan_sel;
  logic wr_len_data;
  logic wr_tristate;
  logic wr_irq_en;
  logic wr_irq_clear;
  logic rd_irq_stat;

  logic [CHAN_PTR_W-1:0] channel_pointer_field_q;
  logic [LEN_W-1:0] len_mem_q [NUM_CHAN];
  logic [NUM_CHAN-1:0] tristate_q;
  logic [NUM_CHAN-1:0] irq_en_q;

  logic cap_valid_q;
  logic [DATA_W-1:0] prdata_q;
  logic pslverr_q;
  logic [NUM_CHAN-1:0] read_mask_q;

  logic pointer_valid;
  logic [1:0] pointer_index;
  logic [LEN_W-1:0] len_selected;
  logic [LEN_W-1:0] len_readback;
  logic [7:0] read_value;

  logic [NUM_CHAN-1:0] e1_mode_q;
  logic [NUM_CHAN-1:0] t1_mode_q;

  logic [NUM_CHAN-1:0] read_clear;
  logic [NUM_CHAN-1:0] write_clear;
  alarm_view_s alarm_view;

  assign req = '{addr: paddr, write: pwrite, wdata: pwdata, strb: pstrb};

  assign setup_sel = decode_reg(req.addr);
  assign access_sel = setup_sel;

  // The answer is prepared one cycle ahead so read data leaves a flip-flop.
  assign pready = pce & cap_valid_q;
  assign access_done = psel & penable & pready;
  assign wr_lane0 = access_done & req.write & req.strb[0];
  assign rd_irq_stat = access_done & ~req.write & (access_sel == REG_IRQ_STAT);

  assign pointer_valid = (channel_pointer_field_q < CHAN_PTR_W'(NUM_CHAN)); // RL1
  assign pointer_index = channel_pointer_field_q[1:0]; // RL1

  // One strobe per writable register; a data write with the pointer out of range is
  // dropped here, so the storage process never sees it.
  always_comb begin
    wr_chan_sel = 1'b0;
    wr_len_data = 1'b0;
    wr_tristate = 1'b0;
    wr_irq_en = 1'b0;
    wr_irq_clear = 1'b0;
    if (wr_lane0) begin
      case (access_sel)
        REG_CHAN_SEL: begin
          wr_chan_sel = 1'b1; // RL1
        end
        REG_LEN_DATA: begin
          wr_len_data = pointer_valid; // RL2
        end
        REG_TRISTATE: begin
          wr_tristate = 1'b1;
        end
        REG_IRQ_EN: begin
          wr_irq_en = 1'b1;
        end
        REG_IRQ_CLEAR: begin
          wr_irq_clear = 1'b1;
        end
        default: begin
          wr_irq_clear = 1'b0;
        end
      endcase
    end
  end

  always_comb begin
    len_selected = LEN_RESET;
    if (pointer_valid) begin
      len_selected = len_mem_q[pointer_index]; // RL2
    end
  end

  // Early silicon returns the code bit-inverted; software that knows the
  // revision undoes it, so the stored value and the line shape stay true.
  always_comb begin
    if (READBACK_FIXED) begin
      len_readback = len_selected;
    end else begin
      len_readback = ~len_selected; // RL5
    end
  end

  always_comb begin
    read_value = REG_RESET;
    case (setup_sel)
      REG_CHAN_SEL: begin
        read_value[CHAN_PTR_LSB +: CHAN_PTR_W] = channel_pointer_field_q;
      end
      REG_LEN_DATA: begin
        if (pointer_valid) begin
          read_value[LEN_LSB +: LEN_W] = len_readback; // RL2 RL5
        end
      end
      REG_TRISTATE: begin
        read_value[CHAN_BITS_LSB +: NUM_CHAN] = tristate_q;
      end
      REG_ALARM_STAT: begin
        read_value[CHAN_BITS_LSB +: NUM_CHAN] = alarm_view.monitor; // RL8
      end
      REG_IRQ_EN: begin
        read_value[CHAN_BITS_LSB +: NUM_CHAN] = irq_en_q;
      end
      REG_IRQ_STAT: begin
        read_value[CHAN_BITS_LSB +: NUM_CHAN] = alarm_view.irq_status; // RL11
      end
      REG_IRQ_CLEAR: begin
        read_value = REG_RESET;
      end
      default: begin
        read_value = REG_RESET;
      end
    endcase
  end

  // Capture the answer once per transfer, whichever phase sees pce first.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_valid_q <= 1'b0;
    end else if (pce) begin
      if (access_done) begin
        cap_valid_q <= 1'b0;
      end else if (psel) begin
        cap_valid_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
      pslverr_q <= 1'b0;
    end else if (pce && psel && !cap_valid_q) begin
      prdata_q <= {24'h000000, read_value};
      pslverr_q <= (setup_sel == REG_NONE);
    end
  end

  // Only the bits the host actually saw are cleared by the read, so an
  // event arriving between capture and completion stays pending.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      read_mask_q <= CHAN_BITS_RESET;
    end else if (pce && psel && !cap_valid_q) begin
      if (setup_sel == REG_IRQ_STAT) begin
        read_mask_q <= alarm_view.irq_status;
      end else begin
        read_mask_q <= CHAN_BITS_RESET;
      end
    end
  end

  assign prdata = prdata_q;
  // The error answer is gated by ready so it never shows outside an access.
  assign pslverr = pslverr_q & pready;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_pointer_field_q <= CHAN_PTR_RESET; // RL6
    end else if (pce && wr_chan_sel) begin
      channel_pointer_field_q <= req.wdata[CHAN_PTR_LSB +: CHAN_PTR_W]; // RL1
    end
  end

  // Pointer values above three address no channel; writes there are dropped.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        len_mem_q[i] <= LEN_RESET; // RL6
      end
    end else if (pce && wr_len_data) begin
      len_mem_q[pointer_index] <= req.wdata[LEN_LSB +: LEN_W]; // RL2
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tristate_q <= CHAN_BITS_RESET; // RL6
    end else if (pce && wr_tristate) begin
      tristate_q <= req.wdata[CHAN_BITS_LSB +: NUM_CHAN]; // RL7
    end
  end

  // Upper enable bits are expected to be written as zero and are not stored.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_q <= CHAN_BITS_RESET; // RL6
    end else if (pce && wr_irq_en) begin
      irq_en_q <= req.wdata[CHAN_BITS_LSB +: NUM_CHAN]; // RL10 RL12
    end
  end

  // The mode flags lag the stored code by one cycle; only line logic reads them.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      e1_mode_q <= CHAN_BITS_RESET;
    end else if (pce) begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        e1_mode_q[i] <= (decode_mode(len_mem_q[i]) == MODE_E1); // RL4
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t1_mode_q <= CHAN_BITS_RESET;
    end else if (pce) begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        t1_mode_q[i] <= (decode_mode(len_mem_q[i]) == MODE_T1); // RL3
      end
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_CHAN; i++) begin
      line_length_code[i] = len_mem_q[i]; // RL3
    end
  end

  assign e1_mode = e1_mode_q;
  assign t1_mode = t1_mode_q;
  assign driver_tristate_bits = tristate_q; // RL7

  // A read clears the status bits it returned; the clear register drops ones.
  always_comb begin
    read_clear = CHAN_BITS_RESET;
    write_clear = CHAN_BITS_RESET;
    if (rd_irq_stat) begin
      read_clear = read_mask_q; // RL9
    end
    if (wr_irq_clear) begin
      write_clear = req.wdata[CHAN_BITS_LSB +: NUM_CHAN];
    end
  end

  alarm_irq_tracker u_alarm (
    .pclk(pclk),
    .presetn(presetn),
    .pce(pce),
    .ais_detect(ais_detect),
    .irq_enable(irq_en_q),
    .read_clear(read_clear),
    .write_clear(write_clear),
    .view(alarm_view),
    .irq(irq) // RL13
  );

endmodule

/* File: tb/line_shape_ais_register_bank_assertions.sv */
`timescale 1ns/100ps
module line_shape_checker
  import line_shape_pkg::*;
(
  input wire logic pclk, // Clock.
  input wire logic presetn, // Reset.
  input wire logic pce, // Enable.
  input wire logic psel, // Select.
  input wire logic penable, // Access.
  input wire logic pwrite, // Write.
  input wire logic [ADDR_W-1:0] paddr, // Address.
  input wire logic [DATA_W-1:0] pwdata, // Data in.
  input wire logic [3:0] pstrb, // Strobes.
  input wire logic [DATA_W-1:0] prdata, // Data out.
  input wire logic pready, // Ready.
  input wire logic pslverr, // Error.
  input wire logic [NUM_CHAN-1:0] ais_detect, // Alarms.
  input wire logic [NUM_CHAN-1:0][LEN_W-1:0] line_length_code, // Codes.
  input wire logic [NUM_CHAN-1:0] e1_mode, // E1.
  input wire logic [NUM_CHAN-1:0] t1_mode, // T1.
  input wire logic [NUM_CHAN-1:0] driver_tristate_bits, // Off.
  input wire logic irq // Interrupt.
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence done_s;
    psel && penable && pready;
  endsequence
  sequence rdclr_s;
    $stable(ais_detect)[*2] ##0 done_s ##0 (!pwrite && paddr == 8'h54 && !$past(penable));
  endsequence
  ready_time_a: assert property (psel && !penable && pce ##1 pce |-> pready)
    else $error("Access phase not ready");
  tri_write_a: assert property (
    done_s ##0 (pwrite && pstrb[0] && paddr == 8'h48) |=>
    driver_tristate_bits == $past(pwdata[3:0])) else $error("Tristate bits wrong");
  mode_e1_a: assert property (
    $past(presetn) && $past(pce) |-> e1_mode[0] == ($past(line_length_code[0]) == 3'h0))
    else $error("E1 flag wrong");
  mode_t1_a: assert property (
    $past(presetn) && $past(pce) |-> t1_mode[3] == ($past(line_length_code[3]) >= 3'h3))
    else $error("T1 flag wrong");
  irq_clear_a: assert property (rdclr_s |=> !irq)
    else $error("Interrupt kept after status read");
  irq_cause_a: assert property (
    $rose(irq) |-> $past(ais_detect) != $past(ais_detect, 2) || $past(pwrite && pready) ||
    $past(pwrite && pready, 2)) else $error("Interrupt without alarm change");
  mon_read_a: assert property (
    done_s ##0 (!pwrite && paddr == 8'h4C && !$past(penable) && $past(pce, 2)) |->
    prdata[3:0] == $past(ais_detect, 2)) else $error("Alarm monitor read wrong");
  err_map_a: assert property (
    done_s ##0 (paddr < 8'h40 || paddr > 8'h58 || paddr[1:0] != 2'h0) |->
    pslverr && prdata == 32'h0) else $error("Unmapped access not refused");
endmodule
bind line_shape_ais_register_bank line_shape_checker line_shape_checker_i (.pclk, .presetn,
  .pce, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
  .ais_detect, .line_length_code, .e1_mode, .t1_mode, .driver_tristate_bits, .irq);

/* File: tb/test_line_shape_ais_register_bank.sv */
`timescale 1ns/100ps
module test_line_shape_ais_register_bank
  import line_shape_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic pce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = 8'h00;
  logic [DATA_W-1:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic [NUM_CHAN-1:0] ais_detect = 4'h0;
  logic [DATA_W-1:0] prdata, rd;
  logic pready, pslverr, er, irq;
  logic [NUM_CHAN-1:0][LEN_W-1:0] line_length_code;
  logic [NUM_CHAN-1:0] e1_mode, t1_mode, driver_tristate_bits;
  int n_mismatch = 0;
  int check_count = 0;
  int code_m [4] = '{0, 0, 0, 0};
  int p, c, t, en_m, stk_m, a;
  always #2.5 pclk = ~pclk;
  line_shape_ais_register_bank line_shape_ais_register_bank_i (.pclk, .presetn, .pce, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .ais_detect,
    .line_length_code, .e1_mode, .t1_mode, .driver_tristate_bits, .irq);
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // The enable may drop for a cycle in the access phase to force a wait state.
  task automatic xfer(input logic [7:0] ad, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    pce <= ($urandom % 3) != 0;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      pce <= 1'b1;
      n++;
      if (n > 20) begin
        n_mismatch++;
        complete_run();
      end
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] ad, input logic [31:0] exp);
    xfer(ad, 1'b0, 32'h0);
    chk(rd, exp);
    chk(32'(er), 32'h0);
  endtask
  initial begin
    void'($urandom(32'hA3F6E734));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      rdchk(8'h40 + 8'(4 * i), i == 1 ? 32'h7 : 32'h0);
    end
    chk(32'(e1_mode), 32'hF);
    for (int i = 0; i < 24; i++) begin
      p = i < 8 ? i % 4 : $urandom % 8;
      c = i < 8 ? i : $urandom % 8;
      xfer(8'h40, 1'b1, 32'(p));
      xfer(8'h44, 1'b1, 32'(c));
      if (p < 4) begin
        code_m[p] = c;
      end
      rdchk(8'h40, 32'(p));
      rdchk(8'h44, p < 4 ? {29'h0, ~3'(code_m[p])} : 32'h0);
      for (int k = 0; k < 4; k++) begin
        chk(32'(line_length_code[k]), 32'(code_m[k]));
        chk(32'(e1_mode[k]), 32'(code_m[k] == 0));
        chk(32'(t1_mode[k]), 32'(code_m[k] >= 3));
      end
      t = $urandom % 16;
      xfer(8'h48, 1'b1, 32'(t));
      rdchk(8'h48, 32'(t));
      chk(32'(driver_tristate_bits), 32'(t));
    end
    stk_m = 0;
    for (int i = 0; i < 10; i++) begin
      en_m = $urandom % 16;
      xfer(8'h50, 1'b1, 32'(en_m));
      a = $urandom % 16;
      stk_m = stk_m | (a ^ ais_detect);
      @(posedge pclk);
      ais_detect <= 4'(a);
      repeat (3) @(posedge pclk);
      chk(32'(irq), 32'((stk_m & en_m) != 0));
      rdchk(8'h4C, 32'(a));
      rdchk(8'h50, 32'(en_m));
      if (i % 2 == 1) begin
        xfer(8'h58, 1'b1, 32'h5);
        stk_m = stk_m & 32'hA;
      end
      rdchk(8'h54, 32'(stk_m));
      @(posedge pclk);
      chk(32'(irq), 32'h0);
      stk_m = 0;
    end
    // Refused accesses must leave the tristate bits and the line length codes untouched.
    foreach (code_m[i]) begin
      xfer(i == 0 ? 8'h5C : 8'h40 + 8'(i), 1'(i % 2), 32'hFF);
      chk(32'(er), 32'h1);
      rdchk(8'h48, 32'(t));
      chk(32'(line_length_code[i]), 32'(code_m[i]));
    end
    // Lane zero carries every register, so a write without it must not land.
    pstrb <= 4'hE;
    xfer(8'h48, 1'b1, 32'(~t));
    pstrb <= 4'hF;
    rdchk(8'h48, 32'(t));
    complete_run();
  end
endmodule
